// ===== core/urcm_pkg.sv
// Purpose: shared constants and carriers for the unit request channel map
// Assumes: 20 MHz clock, word-indexed controller image port
// Notes:   image address is {slot, point}; slot 16 is the request channel
package urcm_pkg;

  // ---------------------------------------------------------------
  // image geometry
  // ---------------------------------------------------------------
  localparam int          NUM_UNITS     = 15;
  localparam int          WORDS_PER_DIR = 4;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 16;
  localparam int          UNIT_ADDR_W   = 5;
  localparam int          BASE_SW_W     = 4;
  localparam int          RANGE_SW_W    = 4;
  localparam logic [4:0]  SLOT_CTRL     = 5'h00;
  localparam logic [4:0]  SLOT_FIRST    = 5'h01;
  localparam logic [4:0]  SLOT_LAST     = 5'h0F;
  localparam logic [4:0]  SLOT_CHANNEL  = 5'h10;
  localparam logic [2:0]  PT_IN_FIRST   = 3'h0;
  localparam logic [2:0]  PT_OUT_FIRST  = 3'h4;
  localparam logic [2:0]  PT_DISC_IN    = 3'h0;
  localparam logic [2:0]  PT_DISC_OUT   = 3'h1;

  // ---------------------------------------------------------------
  // control slot points
  // ---------------------------------------------------------------
  localparam logic [2:0]  PT_STATUS     = 3'h0;
  localparam logic [2:0]  PT_MASK       = 3'h1;
  localparam logic [2:0]  PT_SWITCHES   = 3'h2;

  // ---------------------------------------------------------------
  // discrete bit fields and unit addressing
  // ---------------------------------------------------------------
  localparam int          BCAST_BIT     = 15;
  localparam logic [4:0]  UNIT_OFS_LOW  = 5'h01;
  localparam logic [4:0]  UNIT_OFS_HIGH = 5'h10;
  localparam logic [4:0]  BCAST_UNIT    = 5'h00;

  // ---------------------------------------------------------------
  // event status bits
  // ---------------------------------------------------------------
  localparam int          EVT_W         = 3;
  localparam int          EVT_UNIT_DONE = 0;
  localparam int          EVT_BC_DONE   = 1;
  localparam int          EVT_SCAN_WRAP = 2;
  localparam logic [EVT_W-1:0] MASK_RST  = 3'h0;

  typedef enum logic [1:0] {
    URCM_IDLE = 2'b00,
    URCM_WAIT = 2'b01
  } urcm_state_e;

  typedef logic [WORDS_PER_DIR-1:0][DATA_W-1:0] urcm_words_t;

  // request towards the field transceiver
  typedef struct packed {
    logic                   valid;
    logic                   bcast;
    logic                   immediate;
    logic [UNIT_ADDR_W-1:0] unitAddr;
    urcm_words_t            words;
  } urcm_fld_req_s;

  // answer from the field transceiver
  typedef struct packed {
    logic        ack;
    urcm_words_t words;
  } urcm_fld_rsp_s;

  // controller image port
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              we;
    logic              re;
  } urcm_bus_s;

endpackage

// ===== core/urcm_pin_filter.sv
// Purpose: three-stage synchroniser and agreement filter for switch pins
// Assumes: pins change slowly compared to the clock
// Notes:   output follows once the second and third stages agree
`timescale 1ns/100ps
`default_nettype none
module urcm_pin_filter #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pinIn,
  output var  logic [W-1:0] pinOut
);
  import urcm_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } urcm_filt_s;

  urcm_filt_s   st;
  urcm_filt_s   next_st;
  logic [W-1:0] next_q;

  // ---------------------------------------------------------------
  // per-bit agreement
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign next_q[i] = (st.s2[i] == st.s3[i]) ? st.s3[i] : st.q[i];
    end
  endgenerate

  always_comb begin
    next_st    = st;
    next_st.s1 = pinIn;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.q  = next_q;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pinOut = st.q;

endmodule // urcm_pin_filter
`default_nettype wire

// ===== core/urcm_channel_map.sv
// Purpose: controller image for fifteen field units plus request channel
// Assumes: field transceiver on the same clock, one request at a time
// Notes:   immediate and broadcast requests pre-empt the routine poll
`timescale 1ns/100ps
`default_nettype none

module urcm_channel_map (
  input  wire logic                              clk,
  input  wire logic                              rstn,
  input  wire urcm_pkg::urcm_bus_s               bus,
  output var  logic [urcm_pkg::DATA_W-1:0]       rdata,
  output var  logic                              irq,
  output var  urcm_pkg::urcm_fld_req_s           fldReq,
  input  wire urcm_pkg::urcm_fld_rsp_s           fldRsp,
  input  wire logic [urcm_pkg::RANGE_SW_W-1:0]   addressRangeSwitch,
  input  wire logic [urcm_pkg::BASE_SW_W-1:0]    baseNumberSwitch
);
  import urcm_pkg::*;

  typedef struct packed {
    // registered outputs
    logic [DATA_W-1:0]                rdata;
    logic                             irq;
    urcm_fld_req_s                    fld;

    // scheduler: poll cursor and the request in flight
    urcm_state_e                      st;
    logic [3:0]                       cursor;
    logic [3:0]                       curIdx;
    logic                             curBc;
    logic                             curImm;

    // request bits and their previous copies
    logic [NUM_UNITS-1:0]             reqBits;
    logic                             bcReq;
    logic [NUM_UNITS-1:0]             reqPrev;
    logic                             bcPrev;

    // edges waiting for the link
    logic [NUM_UNITS-1:0]             pending;
    logic                             bcPend;

    // completion flags seen by the controller
    logic [NUM_UNITS-1:0]             doneFlags;
    logic                             bcDone;

    // sticky events and their mask
    logic [EVT_W-1:0]                 status;
    logic [EVT_W-1:0]                 mask;

    // word image: unit answers, unit commands, broadcast words
    logic [NUM_UNITS-1:0][WORDS_PER_DIR-1:0][DATA_W-1:0] inWords;
    logic [NUM_UNITS-1:0][WORDS_PER_DIR-1:0][DATA_W-1:0] outWords;
    urcm_words_t                      bcWords;
  } urcm_map_s;

  // registered state and its next value
  urcm_map_s                 s;
  urcm_map_s                 next_s;
  // filtered switch levels
  logic [RANGE_SW_W-1:0]     rangeSw;
  logic [BASE_SW_W-1:0]      baseSw;

  // ---------------------------------------------------------------
  // switch pins
  // ---------------------------------------------------------------
  // both switches share one filter, but each bit settles on its own
  urcm_pin_filter #(
    .W (RANGE_SW_W + BASE_SW_W)
  ) u_sw_filter (
    .clk    (clk),
    .rstn   (rstn),
    .pinIn  ({addressRangeSwitch, baseNumberSwitch}),
    .pinOut ({rangeSw, baseSw})
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    // address decode
    logic [4:0]           slot;
    logic [2:0]           pt;
    logic [3:0]           sIdx;
    logic [1:0]           wIdx;
    logic                 unitSlot;
    logic                 chanSlot;
    logic                 ctrlSlot;
    logic                 outPt;

    // edge detection and issue bookkeeping
    logic [NUM_UNITS-1:0] edges;
    logic                 bcEdge;
    logic [NUM_UNITS-1:0] issueClr;
    logic                 bcIssueClr;

    // completion and event status
    logic [NUM_UNITS-1:0] doneEvt;
    logic                 bcDoneEvt;
    logic [EVT_W-1:0]     evt;
    logic [EVT_W-1:0]     w1c;

    // scheduler pick and unit addressing
    logic                 found;
    logic [3:0]           pick;
    logic [4:0]           unitOfs;

    // read mux
    logic [DATA_W-1:0]    rd;

    // one pass builds the whole next state from the registered copy
    next_s     = s;
    slot       = bus.addr[7:3];
    pt         = bus.addr[2:0];
    sIdx       = 4'(slot - SLOT_FIRST);
    wIdx       = pt[1:0];
    unitSlot   = (slot >= SLOT_FIRST) && (slot <= SLOT_LAST);
    chanSlot   = (slot == SLOT_CHANNEL);
    ctrlSlot   = (slot == SLOT_CTRL);
    outPt      = (pt >= PT_OUT_FIRST);

    edges      = '0;
    bcEdge     = 1'b0;
    issueClr   = '0;
    bcIssueClr = 1'b0;
    doneEvt    = '0;
    bcDoneEvt  = 1'b0;
    evt        = '0;
    w1c        = '0;
    found      = 1'b0;
    pick       = '0;
    rd         = '0;
    // a nonzero range switch moves the units to the upper address range
    unitOfs    = (rangeSw == '0) ? UNIT_OFS_LOW : UNIT_OFS_HIGH;

    // -------------------------------------------------------------
    // image writes
    // -------------------------------------------------------------
    // writes to unit input words or unmapped points are dropped;
    // the channel discrete inputs are read only as well
    if (bus.we) begin
      if (unitSlot && outPt) begin
        next_s.outWords[sIdx][wIdx] = bus.wdata;
      end else if (chanSlot && pt == PT_DISC_OUT) begin
        next_s.reqBits = bus.wdata[NUM_UNITS-1:0];
        next_s.bcReq   = bus.wdata[BCAST_BIT];
      end else if (chanSlot && outPt) begin
        next_s.bcWords[wIdx] = bus.wdata;
      end else if (ctrlSlot && pt == PT_STATUS) begin
        w1c = bus.wdata[EVT_W-1:0];
      end else if (ctrlSlot && pt == PT_MASK) begin
        next_s.mask = bus.wdata[EVT_W-1:0];
      end
    end

    // -------------------------------------------------------------
    // request bit edges
    // -------------------------------------------------------------
    // the old copy comes from the register, so a bit written high
    // again while already high is not a new edge
    next_s.reqPrev = s.reqBits;
    next_s.bcPrev  = s.bcReq;
    edges          = s.reqBits & ~s.reqPrev;
    bcEdge         = s.bcReq & ~s.bcPrev;

    // -------------------------------------------------------------
    // request scheduler
    // -------------------------------------------------------------
    // priority: broadcast, lowest pending unit, then the poll cursor
    // one request in flight; new edges wait until it is answered
    // the poll cursor is served only when nothing is pending
    case (s.st)
      URCM_IDLE: begin
        // broadcast uses unit address zero, which no unit has
        if (s.bcPend) begin
          bcIssueClr            = 1'b1;
          next_s.curBc          = 1'b1;
          next_s.curImm         = 1'b1;
          next_s.fld.valid      = 1'b1;
          next_s.fld.bcast      = 1'b1;
          next_s.fld.immediate  = 1'b1;
          next_s.fld.unitAddr   = BCAST_UNIT;
          next_s.fld.words      = s.bcWords;
          next_s.st             = URCM_WAIT;
        end else begin
          // scan from the top so the lowest pending unit wins
          for (int i = NUM_UNITS - 1; i >= 0; i--) begin
            if (s.pending[i]) begin
              found = 1'b1;
              pick  = 4'(i);
            end
          end
          // a pending request jumps ahead of the poll cursor
          if (!found) begin
            pick = s.cursor;
          end
          // clear only the edge being served; later edges stay pending
          if (found) begin
            issueClr[pick] = 1'b1;
          end
          // record what is in flight for the completion step
          next_s.curBc          = 1'b0;
          next_s.curImm         = found;
          next_s.curIdx         = pick;
          next_s.fld.valid      = 1'b1;
          next_s.fld.bcast      = 1'b0;
          next_s.fld.immediate  = found;
          // unit number is the index plus the range offset
          next_s.fld.unitAddr   = 5'(pick) + unitOfs;
          // header word passes unchanged: command low, length high
          next_s.fld.words      = s.outWords[pick];
          next_s.st             = URCM_WAIT;
        end
      end

      // hold the request steady until the link answers; answer
      // words are taken only in the ack cycle
      URCM_WAIT: begin
        if (fldRsp.ack) begin
          next_s.fld.valid = 1'b0;
          next_s.st        = URCM_IDLE;
          // broadcast answers carry no unit data and are dropped
          if (!s.curBc) begin
            next_s.inWords[s.curIdx] = fldRsp.words;
          end
          // the cursor moves only when a routine poll finishes
          if (s.curBc) begin
            bcDoneEvt = 1'b1;
          end else if (s.curImm) begin
            doneEvt[s.curIdx] = 1'b1;
          end else if (s.cursor == 4'(NUM_UNITS - 1)) begin
            next_s.cursor      = '0;
            evt[EVT_SCAN_WRAP] = 1'b1;
          end else begin
            next_s.cursor = s.cursor + 4'h1;
          end
          // cursor untouched by pre-empting requests
          if (s.curImm) begin
            next_s.cursor = s.cursor;
          end
        end
      end

      // unreachable with two states; drops any request and returns
      // to idle so the link never sees a stuck valid
      default: begin
        next_s.st        = URCM_IDLE;
        next_s.fld.valid = 1'b0;
      end
    endcase

    // -------------------------------------------------------------
    // pending requests and done flags
    // -------------------------------------------------------------
    // a new edge in the issue cycle is kept
    next_s.pending = (s.pending & ~issueClr) | edges;
    next_s.bcPend  = (s.bcPend & ~bcIssueClr) | bcEdge;

    // done flags need the bit still high; a low bit clears them
    next_s.doneFlags = (s.doneFlags | (doneEvt & s.reqBits)) & s.reqBits;
    next_s.bcDone    = (s.bcDone | (bcDoneEvt & s.bcReq)) & s.bcReq;

    // -------------------------------------------------------------
    // event status and interrupt
    // -------------------------------------------------------------
    // an event wins over a one written to clear in the same cycle
    evt[EVT_UNIT_DONE] = |doneEvt;
    evt[EVT_BC_DONE]   = bcDoneEvt;
    next_s.status      = (s.status & ~w1c) | evt;
    // interrupt follows the next status, so a clear drops it at once
    next_s.irq         = |(next_s.status & next_s.mask);

    // -------------------------------------------------------------
    // read data
    // -------------------------------------------------------------
    // read data stands only in the cycle after the strobe
    if (bus.re) begin
      // points 0 to 3 of a unit slot hold answers, 4 to 7 commands;
      // unmapped points read as zero
      if (unitSlot) begin
        if (outPt) begin
          rd = s.outWords[sIdx][wIdx];
        end else begin
          rd = s.inWords[sIdx][wIdx];
        end
      end else if (chanSlot && pt == PT_DISC_IN) begin
        rd = {s.bcDone, s.doneFlags};
      end else if (chanSlot && pt == PT_DISC_OUT) begin
        rd = {s.bcReq, s.reqBits};
      end else if (chanSlot && outPt) begin
        rd = s.bcWords[wIdx];
      end else if (ctrlSlot && pt == PT_STATUS) begin
        rd = DATA_W'(s.status);
      end else if (ctrlSlot && pt == PT_MASK) begin
        rd = DATA_W'(s.mask);
      end else if (ctrlSlot && pt == PT_SWITCHES) begin
        rd = DATA_W'({rangeSw, baseSw});
      end else begin
        rd = '0;
      end
    end
    next_s.rdata = rd;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // synchronous reset clears the image, requests and flags;
  // the state and the mask take their named reset values
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s        <= '0;
      s.st     <= URCM_IDLE;
      s.mask   <= MASK_RST;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // every output is a copy of a register field
  assign rdata  = s.rdata;
  assign irq    = s.irq;
  assign fldReq = s.fld;

endmodule // urcm_channel_map
`default_nettype wire

// ===== test/urcm_channel_map_checker.sv
// Purpose: port-level assertions for the unit request channel map
// Assumes: one clock domain, range switch zero while requests are made
// Notes:   request bit edges are rebuilt from writes to the channel outputs
`timescale 1ns/100ps
`default_nettype none
module urcm_channel_map_checker (
  input wire logic                            clk,
  input wire logic                            rstn,
  input wire urcm_pkg::urcm_bus_s             bus,
  input wire logic [urcm_pkg::DATA_W-1:0]     rdata,
  input wire logic                            irq,
  input wire urcm_pkg::urcm_fld_req_s         fldReq,
  input wire urcm_pkg::urcm_fld_rsp_s         fldRsp,
  input wire logic [urcm_pkg::RANGE_SW_W-1:0] addressRangeSwitch,
  input wire logic [urcm_pkg::BASE_SW_W-1:0]  baseNumberSwitch
);
  import urcm_pkg::*;
  // ---------------------------------------------------------------
  // request bit shadow
  // ---------------------------------------------------------------
  logic [15:0] shadow;
  logic [15:0] armed;
  logic        busy;
  wire  logic       chWr  = bus.we && bus.addr == 8'h81;
  wire  logic       start = fldReq.valid && !busy && fldReq.immediate;
  wire  logic [3:0] idx   = fldReq.bcast ? 4'hF : 4'(fldReq.unitAddr - 5'h01);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shadow <= 16'h0;
      armed  <= 16'h0;
      busy   <= 1'b0;
    end else begin
      busy   <= fldReq.valid;
      shadow <= chWr ? bus.wdata : shadow;
      armed  <= (armed & ~(start ? 16'h1 << idx : 16'h0))
                | (chWr ? bus.wdata & ~shadow : 16'h0);
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_sw_steady;
    ($stable(addressRangeSwitch) && $stable(baseNumberSwitch)) [*5];
  endsequence
  sequence s_rise_write;
    chWr && (bus.wdata & ~shadow) != 16'h0;
  endsequence
  a_req_held_stable: assert property (
    fldReq.valid && !fldRsp.ack |=> fldReq.valid && $stable(fldReq))
    else $error("request changed while outstanding");
  a_req_drop_ack: assert property (
    fldReq.valid && fldRsp.ack |=> !fldReq.valid)
    else $error("request not retired after ack");
  a_bcast_addr_zero: assert property (
    fldReq.valid && fldReq.bcast |->
      fldReq.unitAddr == BCAST_UNIT && fldReq.immediate)
    else $error("broadcast request malformed");
  a_unit_range_low: assert property (
    s_sw_steady ##0 (addressRangeSwitch == 4'h0 && fldReq.valid
      && !fldReq.bcast) |-> fldReq.unitAddr inside {[5'h01:5'h0F]})
    else $error("unit address outside 1 to 15");
  a_preempt_bound: assert property (
    s_rise_write |-> ##[2:40] start)
    else $error("immediate request not issued in time");
  a_one_per_edge: assert property (
    start |-> armed[idx])
    else $error("immediate request without a new edge");
  a_switch_readback: assert property (
    s_sw_steady ##0 (bus.re && bus.addr == 8'h02) |=>
      rdata == {8'h00, $past(addressRangeSwitch), $past(baseNumberSwitch)})
    else $error("switch readback wrong");
  a_unmapped_zero: assert property (
    bus.re && bus.addr == 8'hFF |=> rdata == 16'h0)
    else $error("unmapped read not zero");
endmodule // urcm_channel_map_checker
bind urcm_channel_map urcm_channel_map_checker u_chk (
  .clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .irq(irq),
  .fldReq(fldReq), .fldRsp(fldRsp), .addressRangeSwitch(addressRangeSwitch),
  .baseNumberSwitch(baseNumberSwitch));
`default_nettype wire

// ===== test/urcm_field_model.sv
// Purpose: behavioural field units answering the request channel
// Assumes: same clock as the device, one request outstanding
// Notes:   answer delay set by the bench; idle words toggle every cycle
`timescale 1ns/100ps
`default_nettype none
module urcm_field_model (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic [3:0]              delay,
  input  wire urcm_pkg::urcm_fld_req_s fldReq,
  output var  urcm_pkg::urcm_fld_rsp_s fldRsp
);
  import urcm_pkg::*;
  logic [3:0] cnt;
  wire  logic hit = fldReq.valid && !fldRsp.ack && cnt == delay;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt    <= 4'h0;
      fldRsp <= '0;
    end else begin
      cnt        <= (fldReq.valid && !fldRsp.ack) ? cnt + 4'h1 : 4'h0;
      fldRsp.ack <= hit;
      for (int i = 0; i < 4; i++) begin
        fldRsp.words[i] <= hit ? {8'hA0 + 8'(i), 3'h0, fldReq.unitAddr}
                               : ~fldRsp.words[i];
      end
    end
  end
endmodule // urcm_field_model
`default_nettype wire

// ===== test/tb_urcm_channel_map.sv
// Purpose: directed test of the unit request channel map
// Assumes: field model echoes point and unit in its response words
// Notes:   base switch held at five throughout
`timescale 1ns/100ps
`default_nettype none
module tb_urcm_channel_map;
  import urcm_pkg::*;
  logic          clk = 1'b0;
  logic          rstn = 1'b0;
  urcm_bus_s     bus = '0;
  logic [15:0]   rdata;
  logic          irq;
  urcm_fld_req_s fldReq;
  urcm_fld_rsp_s fldRsp;
  logic [3:0]    rangeSw = 4'h0;
  logic [3:0]    delay = 4'h1;
  logic          prevV = 1'b0;
  int            num_errors = 0;
  int            num_checks = 0;
  int            immCnt = 0;
  always #25 clk = ~clk;
  urcm_channel_map dut (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
    .irq(irq), .fldReq(fldReq), .fldRsp(fldRsp),
    .addressRangeSwitch(rangeSw), .baseNumberSwitch(4'h5));
  urcm_field_model field (.clk(clk), .rstn(rstn), .delay(delay),
    .fldReq(fldReq), .fldRsp(fldRsp));
  always @(negedge clk) begin
    prevV <= fldReq.valid;
    if (fldReq.valid && !prevV && fldReq.immediate) immCnt <= immCnt + 1;
  end
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.we <= 1'b1;
    @(posedge clk);
    bus.we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] m,
                    input logic [15:0] e);
    @(posedge clk);
    bus.addr <= a;
    bus.re <= 1'b1;
    @(posedge clk);
    bus.re <= 1'b0;
    #1;
    check(rdata & m, e);
  endtask
  task automatic waitReq(input logic b);
    int n;
    n = 0;
    while (!(fldReq.valid && fldReq.immediate && fldReq.bcast == b)
           && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(16'(n < 400), 16'h1);
  endtask
  task automatic waitIdle();
    for (int n = 0; n < 400 && fldReq.valid && fldReq.immediate; n++) begin
      @(posedge clk);
      #1;
    end
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (300) @(posedge clk);
    for (int s = 1; s < 16; s++) begin
      for (int p = 0; p < 4; p++) begin
        rd(8'(s * 8 + p), 16'hFFFF, {8'hA0 + 8'(p), 8'(s)});
        wr(8'(s * 8 + 4 + p), {8'(s), 8'(p)});
        rd(8'(s * 8 + 4 + p), 16'hFFFF, {8'(s), 8'(p)});
      end
    end
    wr(8'h08, 16'h1234);
    rd(8'h08, 16'hFFFF, 16'hA001);
    rd(8'h02, 16'hFFFF, 16'h0005);
    wr(8'hFF, 16'h1234);
    rd(8'hFF, 16'hFFFF, 16'h0000);
    wr(8'h01, 16'h0001);
    wr(8'h00, 16'h0007);
    rd(8'h01, 16'hFFFF, 16'h0001);
    check(16'(irq), 16'h0);
    delay <= 4'h9;
    wr(8'h14, 16'h0312);
    wr(8'h15, 16'h2211);
    wr(8'h81, 16'h0002);
    waitReq(1'b0);
    check(16'(fldReq.unitAddr), 16'h0002);
    check(fldReq.words[0], 16'h0312);
    check(fldReq.words[1], 16'h2211);
    waitIdle();
    rd(8'h80, 16'hFFFF, 16'h0002);
    rd(8'h00, 16'h0001, 16'h0001);
    check(16'(irq), 16'h1);
    repeat (150) @(posedge clk);
    check(16'(immCnt), 16'h1);
    wr(8'h00, 16'h0001);
    rd(8'h00, 16'h0001, 16'h0000);
    check(16'(irq), 16'h0);
    wr(8'h81, 16'h0000);
    rd(8'h80, 16'hFFFF, 16'h0000);
    wr(8'h81, 16'h0008);
    waitReq(1'b0);
    wr(8'h81, 16'h0000);
    waitIdle();
    rd(8'h80, 16'hFFFF, 16'h0000);
    wr(8'h01, 16'h0002);
    wr(8'h84, 16'h0055);
    wr(8'h81, 16'h8000);
    rd(8'h81, 16'hFFFF, 16'h8000);
    waitReq(1'b1);
    check(16'(fldReq.unitAddr), 16'h0000);
    check(fldReq.words[0], 16'h0055);
    waitIdle();
    rd(8'h80, 16'hFFFF, 16'h8000);
    check(16'(irq), 16'h1);
    wr(8'h80, 16'h0000);
    rd(8'h80, 16'hFFFF, 16'h8000);
    check(16'(immCnt), 16'h3);
    wr(8'h81, 16'h0000);
    rangeSw <= 4'h1;
    repeat (300) @(posedge clk);
    rd(8'h08, 16'hFFFF, 16'hA010);
    rd(8'h02, 16'hFFFF, 16'h0015);
    rd(8'h00, 16'h0004, 16'h0004);
    complete_run();
  end
  initial begin
    #(50 * 20000);
    num_errors++;
    complete_run();
  end
endmodule // tb_urcm_channel_map
`default_nettype wire
